//--- hw/pie_pkg.sv
package pie_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] PIE_OFF_CTRL = 8'h00;
  localparam logic [7:0] PIE_OFF_EN0 = 8'h04;
  localparam logic [7:0] PIE_OFF_EN1 = 8'h08;
  localparam logic [7:0] PIE_OFF_STATUS = 8'h0C;
  localparam logic [7:0] PIE_OFF_MASK = 8'h10;

  // Control register field positions
  localparam int PIE_CTRL_GIE_BIT = 7;
  localparam int PIE_CTRL_PGATE_BIT = 6;
  localparam int PIE_CTRL_EDGE_BIT = 0;
  localparam logic [7:0] PIE_CTRL_IMPL = 8'hC1;

  // First enable register field positions
  localparam int PIE_EN0_TMR0_BIT = 5;
  localparam int PIE_EN0_PINCHG_BIT = 4;
  localparam int PIE_EN0_EXT_BIT = 0;
  localparam logic [7:0] PIE_EN0_IMPL = 8'h31;

  // Second enable register field positions, bit 7 down to bit 0
  localparam int PIE_EN1_T1GATE_BIT = 7;
  localparam int PIE_EN1_ADC_BIT = 6;
  localparam int PIE_EN1_RX_BIT = 5;
  localparam int PIE_EN1_TX_BIT = 4;
  localparam int PIE_EN1_SSP_BIT = 3;
  localparam int PIE_EN1_BCOL_BIT = 2;
  localparam int PIE_EN1_T2MATCH_BIT = 1;
  localparam int PIE_EN1_T1OVF_BIT = 0;

  // Status and mask layout: low byte mirrors the first enable register,
  // high byte mirrors the second
  localparam int PIE_STAT_GRP1_LSB = 8;
  localparam logic [15:0] PIE_STAT_IMPL = 16'hFF31;

  // Reset values
  localparam logic [7:0] PIE_CTRL_RST = 8'h00;
  localparam logic [7:0] PIE_EN0_RST = 8'h00;
  localparam logic [7:0] PIE_EN1_RST = 8'h00;
  localparam logic [15:0] PIE_STAT_RST = 16'h0000;
  localparam logic [15:0] PIE_MASK_RST = 16'hFF31;

endpackage

//--- hw/pie_edge_if.sv
`timescale 1ns/1ps
// Carries the external pin and its edge choice to the detector
interface pie_edge_if;
  logic pin; // Sampled external pin level
  logic edge_select; // 1 picks rising, 0 picks falling
  logic edge_pulse; // One-cycle pulse per valid edge
  modport det (input pin, input edge_select, output edge_pulse);
  modport ctl (output pin, output edge_select, input edge_pulse);
endinterface // pie_edge_if

//--- hw/pie_edge_det.sv
`timescale 1ns/1ps
module pie_edge_det
  import pie_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  pie_edge_if.det edge_bus
);

  // Previous pin sample and a flag that says the sample is valid
  typedef struct packed {
    logic prev;
    logic primed;
  } pie_edge_state_t;

  pie_edge_state_t st; // Registered state
  pie_edge_state_t next_st; // Next state

  // Remember the pin; the first sample after reset only primes
  always_comb begin
    next_st = st;
    next_st.prev = edge_bus.pin;
    next_st.primed = 1'b1;
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Rising edge when selected high, falling edge when selected low
  assign edge_bus.edge_pulse = st.primed & (edge_bus.edge_select ? (edge_bus.pin & ~st.prev)
                                                                 : (~edge_bus.pin & st.prev));

  edge_rise_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st.primed && edge_bus.edge_select && edge_bus.pin && !st.prev) |-> edge_bus.edge_pulse)
    else $error("rising edge missed");
  edge_fall_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (!edge_bus.edge_select && edge_bus.pin) |-> !edge_bus.edge_pulse)
    else $error("pulse while pin high in falling mode");

endmodule // pie_edge_det

//--- hw/pie_irq_enables.sv
`timescale 1ns/1ps
module pie_irq_enables
  import pie_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic timer0_overflow_evt,
  input wire logic pin_change_evt,
  input wire logic ext_irq_pin,
  input wire logic [7:0] periph_evt,
  output logic ext_irq_flag,
  output logic core_irq
);

  // Whole state of the block
  typedef struct packed {
    logic [7:0] ctrl; // Global enable, peripheral gate, edge select
    logic [7:0] en0; // First enable register
    logic [7:0] en1; // Second enable register
    logic [15:0] status; // Sticky event flags
    logic [15:0] mask; // Interrupt mask, same layout as status
    logic wr_pend; // Write data phase pending
    logic [7:0] wr_off; // Offset of the pending write
    logic [31:0] rdata; // Read data for the data phase
  } pie_state_t;

  pie_state_t st; // Registered state
  pie_state_t next_st; // Next state

  pie_edge_if edge_bus (); // Link to the edge detector

  logic addr_ok; // Address phase accepted this cycle
  logic [7:0] addr_off; // Word offset within the block
  logic [15:0] events; // Event pulses in status layout
  logic [15:0] pending; // Flags enabled and unmasked
  logic grp0_req; // Core-group request
  logic grp1_req; // Peripheral-group request

  // The pin and edge choice go to the detector
  assign edge_bus.pin = ext_irq_pin;
  assign edge_bus.edge_select = st.ctrl[PIE_CTRL_EDGE_BIT];

  // Edge detector for the external pin
  pie_edge_det u_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .edge_bus(edge_bus)
  );

  // Bus transfer decode; only NONSEQ and SEQ count
  assign addr_ok = hsel & hready & htrans[1];
  assign addr_off = {haddr[7:2], 2'b00};

  // Gather events into the status layout
  always_comb begin
    events = '0;
    events[PIE_EN0_TMR0_BIT] = timer0_overflow_evt;
    events[PIE_EN0_PINCHG_BIT] = pin_change_evt;
    events[PIE_EN0_EXT_BIT] = edge_bus.edge_pulse;
    // Peripheral events follow the second register's bit order
    events[PIE_STAT_GRP1_LSB +: 8] = periph_evt;
  end

  // Next state: writes, sticky flags and read data
  always_comb begin
    next_st = st;
    // Write data phase lands in the addressed register
    if (st.wr_pend) begin
      case (st.wr_off)
        PIE_OFF_CTRL: begin
          next_st.ctrl = hwdata[7:0] & PIE_CTRL_IMPL;
        end
        PIE_OFF_EN0: begin
          // Unused positions drop the written value
          next_st.en0 = hwdata[7:0] & PIE_EN0_IMPL;
        end
        PIE_OFF_EN1: begin
          next_st.en1 = hwdata[7:0];
        end
        PIE_OFF_MASK: begin
          next_st.mask = hwdata[15:0] & PIE_STAT_IMPL;
        end
        default: begin
          // Status is read only; unmapped writes vanish
          next_st.ctrl = st.ctrl;
        end
      endcase
    end
    // Capture a new address phase
    next_st.wr_pend = addr_ok & hwrite;
    next_st.wr_off = addr_off;
    next_st.rdata = '0;
    // Sticky flags; a read clears them but a new event wins
    next_st.status = st.status | events;
    if (addr_ok && !hwrite) begin
      // Read data comes from values that include a write in flight
      case (addr_off)
        PIE_OFF_CTRL: begin
          next_st.rdata = {24'h00_0000, next_st.ctrl};
        end
        PIE_OFF_EN0: begin
          next_st.rdata = {24'h00_0000, next_st.en0};
        end
        PIE_OFF_EN1: begin
          next_st.rdata = {24'h00_0000, next_st.en1};
        end
        PIE_OFF_STATUS: begin
          next_st.rdata = {16'h0000, st.status};
          next_st.status = events;
        end
        PIE_OFF_MASK: begin
          next_st.rdata = {16'h0000, next_st.mask};
        end
        default: begin
          // Unmapped reads answer zero
          next_st.rdata = '0;
        end
      endcase
    end
  end

  // State register; every bit clears on reset except the mask, which loads PIE_MASK_RST
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st.ctrl <= PIE_CTRL_RST;
      st.en0 <= PIE_EN0_RST;
      st.en1 <= PIE_EN1_RST;
      st.status <= PIE_STAT_RST;
      st.mask <= PIE_MASK_RST;
      st.wr_pend <= 1'b0;
      st.wr_off <= 8'h00;
      st.rdata <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

  // Flags that are both enabled and unmasked
  assign pending = st.status & st.mask & {st.en1, st.en0};

  // Core group: timer0, pin change and external pin
  assign grp0_req = pending[PIE_EN0_TMR0_BIT]
                  | pending[PIE_EN0_PINCHG_BIT]
                  | pending[PIE_EN0_EXT_BIT];

  // Peripheral group passes only through the gate
  assign grp1_req = st.ctrl[PIE_CTRL_PGATE_BIT] & (|pending[PIE_STAT_GRP1_LSB +: 8]);

  // Global enable decides whether any group request reaches core_irq; ext_irq_flag is not gated by it
  assign core_irq = st.ctrl[PIE_CTRL_GIE_BIT] & (grp0_req | grp1_req);

  // External flag shown to the core
  assign ext_irq_flag = st.status[PIE_EN0_EXT_BIT];

  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st.rdata;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  global_block_a: assert property (!st.ctrl[PIE_CTRL_GIE_BIT] |-> !core_irq)
    else $error("interrupt without global enable");

  periph_gate_a: assert property ((!st.ctrl[PIE_CTRL_PGATE_BIT] && !grp0_req) |-> !core_irq)
    else $error("peripheral interrupt passed a closed gate");

  timer0_gate_a: assert property (
    (st.ctrl[PIE_CTRL_GIE_BIT] && st.status[PIE_EN0_TMR0_BIT] && st.mask[PIE_EN0_TMR0_BIT])
    |-> (core_irq || !st.en0[PIE_EN0_TMR0_BIT]))
    else $error("enabled timer0 flag gave no interrupt");

  pin_change_a: assert property (
    (core_irq && st.status[PIE_STAT_GRP1_LSB +: 8] == 8'h00
     && !st.status[PIE_EN0_TMR0_BIT] && !st.status[PIE_EN0_EXT_BIT])
    |-> st.en0[PIE_EN0_PINCHG_BIT])
    else $error("pin-change interrupt while disabled");

  ext_vector_a: assert property (
    (edge_bus.edge_pulse && st.ctrl[PIE_CTRL_GIE_BIT] && st.en0[PIE_EN0_EXT_BIT]
     && st.mask[PIE_EN0_EXT_BIT] && !(addr_ok && !hwrite) && !st.wr_pend)
    |=> core_irq && ext_irq_flag)
    else $error("external edge did not reach the core");

  ext_flag_set_a: assert property (edge_bus.edge_pulse |=> ext_irq_flag)
    else $error("external flag not set after edge");

  unused_zero_a: assert property ((st.en0 & ~PIE_EN0_IMPL) == 8'h00)
    else $error("unused enable bits set");

  reset_clear_a: assert property ($rose(hresetn) |-> (st.en0 == 8'h00 && st.en1 == 8'h00))
    else $error("enables not clear after reset");

  en1_write_a: assert property (
    (addr_ok && hwrite && addr_off == PIE_OFF_EN1) ##1 1'b1
    |=> st.en1 == $past(hwdata[7:0]))
    else $error("second enable register lost a write");

  en0_read_a: assert property (
    (addr_ok && !hwrite && addr_off == PIE_OFF_EN0 && !st.wr_pend)
    |=> hrdata == {24'h00_0000, $past(st.en0)})
    else $error("first enable register read back wrong");

  // Flag bookkeeping, register reads and writes, gating and edge choice
  // Every event leaves its flag set, even across a status read
  status_set_a: assert property (
    (events != 16'h0000)
    |=> ((st.status & $past(events)) == $past(events)))
    else $error("event flag not set");

  // Flags stay set until software reads the status word
  status_hold_a: assert property (
    !(addr_ok && !hwrite && addr_off == PIE_OFF_STATUS)
    |=> ((st.status & $past(st.status)) == $past(st.status)))
    else $error("flag dropped without a status read");

  // A status read keeps only the events of that same cycle
  status_clear_a: assert property (
    (addr_ok && !hwrite && addr_off == PIE_OFF_STATUS)
    |=> (st.status == $past(events)))
    else $error("status read did not clear the flags");

  // A status read returns the flags as they stood
  status_read_a: assert property (
    (addr_ok && !hwrite && addr_off == PIE_OFF_STATUS)
    |=> (hrdata == {16'h0000, $past(st.status)}))
    else $error("status read returned wrong flags");

  // Control register reads back its stored value
  ctrl_read_a: assert property (
    (addr_ok && !hwrite && addr_off == PIE_OFF_CTRL && !st.wr_pend)
    |=> (hrdata == {24'h00_0000, $past(st.ctrl)}))
    else $error("control register read back wrong");

  // Second enable register reads back its stored value
  en1_read_a: assert property (
    (addr_ok && !hwrite && addr_off == PIE_OFF_EN1 && !st.wr_pend)
    |=> (hrdata == {24'h00_0000, $past(st.en1)}))
    else $error("second enable register read back wrong");

  // Mask register reads back its stored value
  mask_read_a: assert property (
    (addr_ok && !hwrite && addr_off == PIE_OFF_MASK && !st.wr_pend)
    |=> (hrdata == {16'h0000, $past(st.mask)}))
    else $error("mask register read back wrong");

  // Reads beyond the last register answer zero
  unmapped_read_a: assert property (
    (addr_ok && !hwrite && addr_off > PIE_OFF_MASK)
    |=> (hrdata == 32'h0000_0000))
    else $error("unmapped read not zero");

  // A write to the first enable register keeps only implemented bits
  en0_write_a: assert property (
    (addr_ok && hwrite && addr_off == PIE_OFF_EN0) ##1 1'b1
    |=> (st.en0 == ($past(hwdata[7:0]) & PIE_EN0_IMPL)))
    else $error("first enable register lost a write");

  // A control write lands, edge select included
  ctrl_write_a: assert property (
    (addr_ok && hwrite && addr_off == PIE_OFF_CTRL) ##1 1'b1
    |=> (st.ctrl == ($past(hwdata[7:0]) & PIE_CTRL_IMPL)))
    else $error("control register lost a write");

  // Control bits outside the three fields stay zero
  ctrl_unused_a: assert property (
    (st.ctrl & ~PIE_CTRL_IMPL)
    == 8'h00)
    else $error("unused control bits set");

  // An enabled peripheral flag passes an open gate
  periph_pass_a: assert property (
    (st.ctrl[PIE_CTRL_GIE_BIT] && st.ctrl[PIE_CTRL_PGATE_BIT]
     && (st.status[PIE_STAT_GRP1_LSB +: 8] & st.mask[PIE_STAT_GRP1_LSB +: 8] & st.en1) != 8'h00) |-> core_irq)
    else $error("enabled peripheral flag gave no interrupt");

  // An enabled pin-change flag reaches the core
  pin_change_pass_a: assert property (
    (st.ctrl[PIE_CTRL_GIE_BIT] && st.status[PIE_EN0_PINCHG_BIT] && st.mask[PIE_EN0_PINCHG_BIT]
     && st.en0[PIE_EN0_PINCHG_BIT]) |-> core_irq)
    else $error("enabled pin-change flag gave no interrupt");

  // An enabled external flag reaches the core
  ext_pass_a: assert property (
    (st.ctrl[PIE_CTRL_GIE_BIT] && st.status[PIE_EN0_EXT_BIT] && st.mask[PIE_EN0_EXT_BIT]
     && st.en0[PIE_EN0_EXT_BIT]) |-> core_irq)
    else $error("enabled external flag gave no interrupt");

  // A lone external flag interrupts only when enabled
  ext_block_a: assert property (
    (core_irq && (st.status & ~(16'h0001 << PIE_EN0_EXT_BIT)) == 16'h0000)
    |-> st.en0[PIE_EN0_EXT_BIT])
    else $error("external interrupt while disabled");

  // A lone timer0 flag interrupts only when enabled
  timer0_block_a: assert property (
    (core_irq && (st.status & ~(16'h0001 << PIE_EN0_TMR0_BIT)) == 16'h0000)
    |-> st.en0[PIE_EN0_TMR0_BIT])
    else $error("timer0 interrupt while disabled");

  // Outputs and control are quiet right after reset
  reset_outputs_a: assert property (
    $rose(hresetn)
    |-> (!core_irq && !ext_irq_flag && hrdata == 32'h0000_0000 && st.ctrl == PIE_CTRL_RST))
    else $error("outputs not quiet after reset");

  // Mask bits outside the implemented layout stay zero
  mask_unused_a: assert property (
    (st.mask & ~PIE_STAT_IMPL)
    == 16'h0000)
    else $error("unused mask bits set");

  // Status bits outside the implemented layout stay zero
  status_unused_a: assert property (
    (st.status & ~PIE_STAT_IMPL)
    == 16'h0000)
    else $error("unused status bits set");

  // A pulse in rising mode follows a low to high pin change
  rise_select_a: assert property (
    (edge_bus.edge_pulse && st.ctrl[PIE_CTRL_EDGE_BIT])
    |-> (ext_irq_pin && !$past(ext_irq_pin)))
    else $error("rising-mode pulse without a rising edge");

  // A pulse in falling mode follows a high to low pin change
  fall_select_a: assert property (
    (edge_bus.edge_pulse && !st.ctrl[PIE_CTRL_EDGE_BIT])
    |-> (!ext_irq_pin && $past(ext_irq_pin)))
    else $error("falling-mode pulse without a falling edge");

endmodule // pie_irq_enables

//--- bench/pie_periph_model.sv
`timescale 1ns/1ps
// Stand-in for the on-chip event sources and the external pin
module pie_periph_model (
  input wire logic hclk,
  output logic timer0_overflow_evt,
  output logic pin_change_evt,
  output logic [7:0] periph_evt,
  output logic ext_irq_pin
);
  // Every source is quiet at time zero
  initial begin
    timer0_overflow_evt = 1'b0;
    pin_change_evt = 1'b0;
    periph_evt = 8'h00;
    ext_irq_pin = 1'b0;
  end
  // One-cycle pulses, laid out like the status word
  task automatic fire(input logic [15:0] src);
    @(posedge hclk);
    timer0_overflow_evt <= src[5];
    pin_change_evt <= src[4];
    periph_evt <= src[15:8];
    @(posedge hclk);
    timer0_overflow_evt <= 1'b0;
    pin_change_evt <= 1'b0;
    periph_evt <= 8'h00;
  endtask
  // Pin level moves just after an edge
  task automatic set_pin(input logic v);
    @(posedge hclk);
    ext_irq_pin <= v;
  endtask
endmodule // pie_periph_model

//--- bench/peripheral_interrupt_enables_test.sv
`timescale 1ns/1ps
module peripheral_interrupt_enables_test;
  import pie_pkg::*;
  // One row: settings, source pattern, expected interrupt line
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] en0;
    logic [7:0] en1;
    logic [15:0] src;
    logic irq;
  } pie_row_t;
  logic hclk, hresetn, hsel, hwrite, hready, hresp, ext_irq_flag, core_irq, t0_evt, pc_evt, pin;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] p_evt;
  int err_total, samples_checked;
  pie_row_t rows [7] = '{
    '{8'h80, 8'h20, 8'h00, 16'h0020, 1'b1}, '{8'h80, 8'h10, 8'h00, 16'h0020, 1'b0},
    '{8'h80, 8'h10, 8'h00, 16'h0010, 1'b1}, '{8'h00, 8'h30, 8'h00, 16'h0020, 1'b0},
    '{8'h80, 8'h00, 8'hFF, 16'h0800, 1'b0}, '{8'hC0, 8'h00, 8'h08, 16'h0800, 1'b1},
    '{8'hC0, 8'h00, 8'hF7, 16'h0800, 1'b0}};
  logic [7:0] offs [6] = '{PIE_OFF_CTRL, PIE_OFF_EN0, PIE_OFF_EN1, PIE_OFF_STATUS, PIE_OFF_MASK, 8'h14};
  logic [31:0] rst_vals [6] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_FF31,
    32'h0000_0000};

  pie_irq_enables u_pie_irq_enables (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .timer0_overflow_evt(t0_evt),
    .pin_change_evt(pc_evt), .ext_irq_pin(pin), .periph_evt(p_evt), .ext_irq_flag(ext_irq_flag),
    .core_irq(core_irq));
  pie_periph_model u_pie_periph_model (.hclk(hclk), .timer0_overflow_evt(t0_evt),
    .pin_change_evt(pc_evt), .periph_evt(p_evt), .ext_irq_pin(pin));

  // 10 MHz clock
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      err_total++;
    end
  endtask
  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Bounded wait for hready at a rising edge
  task automatic wait_rdy();
    int n;
    for (n = 0; n < 50; n++) begin
      @(posedge hclk);
      if (hready === 1'b1) break;
    end
    if (n == 50) begin
      $display("CHECK FAILED at %0t: bus hang", $time);
      err_total++;
      close_out();
    end
  endtask
  // One single-word transfer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask
  // Bounded wait for the external flag
  task automatic wait_flag();
    for (int n = 0; n < 20; n++) begin
      @(posedge hclk);
      #1;
      if (ext_irq_flag === 1'b1) return;
    end
    $display("CHECK FAILED at %0t: external flag never set", $time);
    err_total++;
    close_out();
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = '0;
    err_total = 0;
    samples_checked = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, unmapped place included
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, offs[i], '0, rd);
      check(rd, rst_vals[i]);
    end
    check({hresp, hready}, 2'b01);
    bus(1'b1, PIE_OFF_EN0, 32'h0000_00FF, rd);
    bus(1'b0, PIE_OFF_EN0, '0, rd);
    check(rd, 32'h0000_0031);
    bus(1'b1, PIE_OFF_EN1, 32'h0000_00A5, rd);
    bus(1'b0, PIE_OFF_EN1, '0, rd);
    check(rd, 32'h0000_00A5);
    // Source gating table
    foreach (rows[i]) begin
      bus(1'b1, PIE_OFF_CTRL, {24'h00_0000, rows[i].ctrl}, rd);
      bus(1'b1, PIE_OFF_EN0, {24'h00_0000, rows[i].en0}, rd);
      bus(1'b1, PIE_OFF_EN1, {24'h00_0000, rows[i].en1}, rd);
      u_pie_periph_model.fire(rows[i].src);
      #1;
      check(core_irq, rows[i].irq);
      bus(1'b0, PIE_OFF_STATUS, '0, rd);
      check(rd, {16'h0000, rows[i].src});
    end
    // External pin, rising then falling selection
    bus(1'b1, PIE_OFF_CTRL, 32'h0000_0081, rd);
    bus(1'b1, PIE_OFF_EN0, 32'h0000_0001, rd);
    u_pie_periph_model.set_pin(1'b1);
    wait_flag();
    check({ext_irq_flag, core_irq}, 2'b11);
    bus(1'b0, PIE_OFF_STATUS, '0, rd);
    check(rd, 32'h0000_0001);
    u_pie_periph_model.set_pin(1'b0);
    repeat (4) @(posedge hclk);
    #1;
    check(ext_irq_flag, 1'b0);
    bus(1'b1, PIE_OFF_CTRL, 32'h0000_0080, rd);
    u_pie_periph_model.set_pin(1'b1);
    u_pie_periph_model.set_pin(1'b0);
    wait_flag();
    check({ext_irq_flag, core_irq}, 2'b11);
    bus(1'b1, PIE_OFF_EN0, 32'h0000_0000, rd);
    #1;
    check({ext_irq_flag, core_irq}, 2'b10);
    bus(1'b1, PIE_OFF_EN0, 32'h0000_0001, rd);
    bus(1'b1, PIE_OFF_CTRL, 32'h0000_0000, rd);
    #1;
    check(core_irq, 1'b0);
    // Reset in mid-run clears the enables
    @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    check({ext_irq_flag, core_irq}, 2'b00);
    bus(1'b0, PIE_OFF_EN1, '0, rd);
    check(rd, 32'h0000_0000);
    bus(1'b0, PIE_OFF_EN0, '0, rd);
    check(rd, {24'h00_0000, PIE_EN0_RST});
    close_out();
  end
endmodule // peripheral_interrupt_enables_test
